/* core/agcc_pkg.sv */
package agcc_pkg;
  // APB register byte offsets.
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ERROR = 8'h08;
  localparam logic [7:0] ADDR_POS = 8'h0c;
  localparam logic [7:0] ADDR_SCALE = 8'h10;
  localparam logic [7:0] ADDR_SPEED = 8'h14;
  localparam logic [7:0] ADDR_MAXSPEED = 8'h18;
  localparam logic [7:0] ADDR_ACCEL = 8'h1c;
  localparam logic [7:0] ADDR_DECEL = 8'h20;
  localparam logic [7:0] ADDR_JERK = 8'h24;
  localparam logic [7:0] ADDR_MODES = 8'h28;
  localparam logic [7:0] ADDR_BLEND = 8'h2c;
  localparam logic [7:0] ADDR_BLENDMAX = 8'h30;
  localparam logic [7:0] ADDR_TARGET = 8'h34;
  // Command register fields.
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 3;
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_MOVE = 3'h1;
  localparam logic [2:0] OP_HOME = 3'h2;
  localparam logic [2:0] OP_HALT = 3'h3;
  localparam logic [2:0] OP_TUNE = 3'h4;
  localparam logic [2:0] OP_RESET = 3'h5;
  localparam logic [2:0] OP_DONE = 3'h6;
  // Mode register field positions.
  localparam int MODE_QUEUE_LSB = 0;
  localparam int MODE_LAUNCH_LSB = 8;
  localparam int MODE_BLEND_LSB = 16;
  localparam logic [7:0] QUEUE_MAX = 8'h05;
  localparam logic [7:0] LAUNCH_MAX = 8'h01;
  localparam logic [7:0] BLEND_MAX = 8'h01;
  // Reset values.
  localparam logic [31:0] SCALE_RESET = 32'h0000_0001;
  localparam logic [31:0] MAXSPEED_RESET = 32'h0000_ffff;
  localparam logic [31:0] BLENDMAX_RESET = 32'h0000_0064;
  // Error codes.
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_TUNE_RUN = 16'h1f50;
  localparam logic [15:0] ERR_NOT_READY = 16'h2000;
  localparam logic [15:0] ERR_ST_DISABLED = 16'h2001;
  localparam logic [15:0] ERR_ST_STANDBY = 16'h2002;
  localparam logic [15:0] ERR_ST_MOVING = 16'h2003;
  localparam logic [15:0] ERR_ST_HOMING = 16'h2004;
  localparam logic [15:0] ERR_ST_STOPPING = 16'h2005;
  localparam logic [15:0] ERR_ST_FAULT = 16'h2006;
  localparam logic [15:0] ERR_SERVO_OFF = 16'h2007;
  localparam logic [15:0] ERR_MODULE_STOP = 16'h2010;
  localparam logic [15:0] ERR_LINK_LOST = 16'h2011;
  localparam logic [15:0] ERR_POS_RANGE = 16'h2012;
  localparam logic [15:0] ERR_SPEED = 16'h2013;
  localparam logic [15:0] ERR_ACCEL = 16'h2014;
  localparam logic [15:0] ERR_DECEL = 16'h2015;
  localparam logic [15:0] ERR_JERK = 16'h2016;
  localparam logic [15:0] ERR_QUEUE = 16'h201a;
  localparam logic [15:0] ERR_LAUNCH = 16'h201b;
  localparam logic [15:0] ERR_BLENDSEL = 16'h201c;
  localparam logic [15:0] ERR_BLENDVAL = 16'h201d;
  localparam logic [15:0] ERR_AXIS_FAULT = 16'h201e;
  localparam logic [15:0] ERR_SEND_RANGE = 16'h201f;
endpackage : agcc_pkg

/* core/agcc_pos_scaler.sv */
`timescale 1ns/1ps
`default_nettype none
module agcc_pos_scaler (
  // Operands.
  input wire logic signed [31:0] position,
  input wire logic signed [31:0] scale,
  // Result.
  output logic signed [31:0] pulses,
  output logic out_of_range
);
  logic signed [63:0] product;
  // The product is kept at full width so any overflow of the 32-bit span is seen, not wrapped.
  always_comb begin
    product = 64'(position) * 64'(scale);
    pulses = product[31:0];
    out_of_range = (product > 64'sh0000_0000_7fff_ffff) || (product < -64'sh0000_0000_8000_0000);
  end
endmodule : agcc_pos_scaler
`default_nettype wire

/* core/agcc_checker.sv */
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Tuning request while module runs is refused with code 1F50.
// - Group command before operation-ready is rejected with 2000.
// - Command illegal in current group state rejected with 2001..2006 by state.
// - Any member axis not servo-on rejects the command with 2007.
// - Module switching to stop during operation aborts it, code 2010.
// - Link loss during operation aborts it, code 2011.
// - Position scaled to pulses outside signed 32 bits rejected with 2012.
// - Position to drive beyond 32-bit pulse range flags 201F, not sent.
// - Speed zero, negative or above maximum rejected with 2013.
// - Negative acceleration 2014, deceleration 2015, jerk 2016.
// - Queue policy selector must be 0..5, else 201A.
// - Launch policy selector must be 0 or 1, else 201B.
// - Blend policy selector must be 0 or 1, else 201C.
// - Blend setting outside its range rejected with 201D.
// - Member axis fault halts group, 201E; host error-resets before new commands.
module agcc_checker #(
  parameter int AXES = 4
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System status.
  input wire logic module_run,
  input wire logic link_up,
  input wire logic group_ready,
  input wire logic [AXES-1:0] axis_servo_on,
  input wire logic [AXES-1:0] axis_fault,
  // Drive side.
  input wire logic op_done,
  output logic [31:0] drive_position,
  output logic drive_send,
  output logic group_halt,
  output logic tune_start
);
  typedef enum {GS_DISABLED, GS_STANDBY, GS_MOVING, GS_HOMING, GS_STOPPING, GS_FAULT} agcc_gstate_type;

  typedef struct packed {
    agcc_gstate_type gstate;
    logic enabled;
    logic run_q;
    logic [15:0] err;
    logic [31:0] pos;
    logic [31:0] scale;
    logic [31:0] speed;
    logic [31:0] maxspeed;
    logic [31:0] accel;
    logic [31:0] decel;
    logic [31:0] jerk;
    logic [31:0] modes;
    logic [31:0] blend;
    logic [31:0] blendmax;
    logic [31:0] target;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] drive_position;
    logic drive_send;
    logic group_halt;
    logic tune_start;
  } agcc_state_type;

  agcc_state_type state;
  agcc_state_type next_state;

  logic scale_ovf;
  logic signed [31:0] send_pulses;
  logic send_ovf;
  logic [AXES-1:0] servo_off;
  logic [AXES-1:0] faulted;

  // Command position scaled when the command is checked.
  agcc_pos_scaler u_cmd_scale (
    .position(state.pos),
    .scale(state.scale),
    .pulses(),
    .out_of_range(scale_ovf)
  );

  // Pulses handed to the drives come from their own path, so the send guard does not lean on the command check.
  // With a same-cycle send it sees the same operands, so it only trips if the command check is ever bypassed.
  agcc_pos_scaler u_send_scale (
    .position(state.pos),
    .scale(state.scale),
    .pulses(send_pulses),
    .out_of_range(send_ovf)
  );

  generate
    for (genvar i = 0; i < AXES; i++) begin : g_axis
      assign servo_off[i] = !axis_servo_on[i];
      assign faulted[i] = axis_fault[i];
    end
  endgenerate

  function automatic logic [15:0] agcc_state_code(input agcc_gstate_type s);
    logic [15:0] c;
    c = agcc_pkg::ERR_ST_DISABLED;
    case (s)
      GS_DISABLED: c = agcc_pkg::ERR_ST_DISABLED;
      GS_STANDBY: c = agcc_pkg::ERR_ST_STANDBY;
      GS_MOVING: c = agcc_pkg::ERR_ST_MOVING;
      GS_HOMING: c = agcc_pkg::ERR_ST_HOMING;
      GS_STOPPING: c = agcc_pkg::ERR_ST_STOPPING;
      GS_FAULT: c = agcc_pkg::ERR_ST_FAULT;
      default: c = agcc_pkg::ERR_ST_DISABLED;
    endcase
    return c;
  endfunction : agcc_state_code

  always_comb begin
    logic wr;
    logic rd;
    logic busy;
    logic [2:0] op;
    logic [15:0] code;
    logic [7:0] qsel;
    logic [7:0] lsel;
    logic [7:0] bsel;

    wr = psel && penable && pwrite;
    rd = psel && !penable && !pwrite;
    busy = (state.gstate == GS_MOVING) || (state.gstate == GS_HOMING);
    op = pwdata[agcc_pkg::CMD_OP_LSB +: agcc_pkg::CMD_OP_W];
    qsel = state.modes[agcc_pkg::MODE_QUEUE_LSB +: 8];
    lsel = state.modes[agcc_pkg::MODE_LAUNCH_LSB +: 8];
    bsel = state.modes[agcc_pkg::MODE_BLEND_LSB +: 8];
    code = agcc_pkg::ERR_NONE;

    next_state = state;
    // Run level of the cycle before, so a stop is seen as an edge and not as a held level.
    next_state.run_q = module_run;
    next_state.pready = psel && !penable;
    next_state.pslverr = 1'b0;
    next_state.drive_send = 1'b0;
    next_state.tune_start = 1'b0;
    next_state.group_halt = (state.gstate == GS_STOPPING) || (state.gstate == GS_FAULT);

    if (state.gstate == GS_STOPPING) begin
      next_state.gstate = GS_STANDBY;
    end
    if (busy && op_done) begin
      next_state.gstate = GS_STANDBY;
    end

    // Reads are answered one cycle after setup so pready and prdata rise together.
    if (rd) begin
      case (paddr)
        agcc_pkg::ADDR_STATUS: next_state.prdata = {24'h0, link_up, module_run, group_ready,
                                                    state.enabled, 1'b0, 3'(state.gstate)};
        agcc_pkg::ADDR_ERROR: next_state.prdata = {16'h0, state.err};
        agcc_pkg::ADDR_POS: next_state.prdata = state.pos;
        agcc_pkg::ADDR_SCALE: next_state.prdata = state.scale;
        agcc_pkg::ADDR_SPEED: next_state.prdata = state.speed;
        agcc_pkg::ADDR_MAXSPEED: next_state.prdata = state.maxspeed;
        agcc_pkg::ADDR_ACCEL: next_state.prdata = state.accel;
        agcc_pkg::ADDR_DECEL: next_state.prdata = state.decel;
        agcc_pkg::ADDR_JERK: next_state.prdata = state.jerk;
        agcc_pkg::ADDR_MODES: next_state.prdata = state.modes;
        agcc_pkg::ADDR_BLEND: next_state.prdata = state.blend;
        agcc_pkg::ADDR_BLENDMAX: next_state.prdata = state.blendmax;
        agcc_pkg::ADDR_TARGET: next_state.prdata = state.target;
        agcc_pkg::ADDR_CMD: next_state.prdata = 32'h0;
        default: begin
          next_state.prdata = 32'h0;
          next_state.pslverr = 1'b1;
        end
      endcase
    end else if (psel && !penable) begin
      next_state.prdata = 32'h0;
      if (paddr > agcc_pkg::ADDR_TARGET || paddr[1:0] != 2'h0 || paddr == agcc_pkg::ADDR_STATUS
          || paddr == agcc_pkg::ADDR_ERROR) begin
        next_state.pslverr = 1'b1;
      end
    end

    // Write refusal is decided at setup and held in pslverr, so the access edge can veto the write.
    if (wr && !state.pslverr) begin
      case (paddr)
        agcc_pkg::ADDR_POS: next_state.pos = pwdata;
        agcc_pkg::ADDR_SCALE: next_state.scale = pwdata;
        agcc_pkg::ADDR_SPEED: next_state.speed = pwdata;
        agcc_pkg::ADDR_MAXSPEED: next_state.maxspeed = pwdata;
        agcc_pkg::ADDR_ACCEL: next_state.accel = pwdata;
        agcc_pkg::ADDR_DECEL: next_state.decel = pwdata;
        agcc_pkg::ADDR_JERK: next_state.jerk = pwdata;
        agcc_pkg::ADDR_MODES: next_state.modes = pwdata;
        agcc_pkg::ADDR_BLEND: next_state.blend = pwdata;
        agcc_pkg::ADDR_BLENDMAX: next_state.blendmax = pwdata;
        agcc_pkg::ADDR_CMD: begin
          if (op == agcc_pkg::OP_RESET) begin
            if (state.gstate == GS_FAULT && faulted == '0) begin
              next_state.gstate = GS_STANDBY;
            end
            next_state.err = agcc_pkg::ERR_NONE;
          end else if (op == agcc_pkg::OP_TUNE) begin
            if (module_run) begin
              code = agcc_pkg::ERR_TUNE_RUN;
            end else begin
              next_state.tune_start = 1'b1;
            end
          end else if (op == agcc_pkg::OP_HALT) begin
            if (busy) begin
              next_state.gstate = GS_STOPPING;
            end else begin
              code = agcc_state_code(state.gstate);
            end
          end else if (op == agcc_pkg::OP_MOVE || op == agcc_pkg::OP_HOME) begin
            // Checks run in priority order: readiness, state, servo, then arguments.
            // Not ready check
            if (!group_ready) begin
              code = agcc_pkg::ERR_NOT_READY;
            end else if (state.gstate != GS_STANDBY) begin
              code = agcc_state_code(state.gstate);
            end else if (servo_off != '0) begin
              code = agcc_pkg::ERR_SERVO_OFF;
            end else if (op == agcc_pkg::OP_MOVE && scale_ovf) begin
              code = agcc_pkg::ERR_POS_RANGE;
            end else if ($signed(state.speed) <= 0 || $signed(state.speed) > $signed(state.maxspeed)) begin
              code = agcc_pkg::ERR_SPEED;
            end else if (state.accel[31]) begin
              code = agcc_pkg::ERR_ACCEL;
            end else if (state.decel[31]) begin
              code = agcc_pkg::ERR_DECEL;
            end else if (state.jerk[31]) begin
              code = agcc_pkg::ERR_JERK;
            end else if (qsel > agcc_pkg::QUEUE_MAX) begin
              code = agcc_pkg::ERR_QUEUE;
            end else if (lsel > agcc_pkg::LAUNCH_MAX) begin
              code = agcc_pkg::ERR_LAUNCH;
            end else if (bsel > agcc_pkg::BLEND_MAX) begin
              code = agcc_pkg::ERR_BLENDSEL;
            end else if ($signed(state.blend) < 0 || $signed(state.blend) > $signed(state.blendmax)) begin
              code = agcc_pkg::ERR_BLENDVAL;
            end else if (op == agcc_pkg::OP_MOVE) begin
              if (send_ovf) begin
                code = agcc_pkg::ERR_SEND_RANGE;
              end else begin
                next_state.target = state.pos;
                next_state.gstate = GS_MOVING;
                next_state.drive_position = send_pulses;
                next_state.drive_send = 1'b1;
              end
            end else begin
              next_state.gstate = GS_HOMING;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Faults outrank a command in the same cycle, so the abort codes win.
    if (busy || state.gstate == GS_STOPPING) begin
      if (state.run_q && !module_run) begin
        code = agcc_pkg::ERR_MODULE_STOP;
        next_state.gstate = GS_STOPPING;
      end
      if (!link_up) begin
        code = agcc_pkg::ERR_LINK_LOST;
        next_state.gstate = GS_STOPPING;
      end
      // A stop under way runs out even while the link stays down;
      // re-entering it every cycle would hold the group halted for good.
      if (state.gstate == GS_STOPPING) begin
        next_state.gstate = GS_STANDBY;
      end
    end

    if (faulted != '0 && state.gstate != GS_DISABLED && state.gstate != GS_FAULT) begin
      code = agcc_pkg::ERR_AXIS_FAULT;
      next_state.gstate = GS_FAULT;
      next_state.drive_send = 1'b0;
    end

    if (next_state.gstate == GS_STOPPING || next_state.gstate == GS_FAULT) begin
      next_state.group_halt = 1'b1;
    end

    if (code != agcc_pkg::ERR_NONE) begin
      next_state.err = code;
    end

    // The group enables itself once after reset; enabling by command lies outside this block.
    if (state.gstate == GS_DISABLED) begin
      next_state.gstate = GS_STANDBY;
      next_state.enabled = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= '0;
      state.gstate <= GS_DISABLED;
      state.scale <= agcc_pkg::SCALE_RESET;
      state.maxspeed <= agcc_pkg::MAXSPEED_RESET;
      state.blendmax <= agcc_pkg::BLENDMAX_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign prdata = state.prdata;
  assign pready = state.pready;
  assign pslverr = state.pslverr;
  assign drive_position = state.drive_position;
  assign drive_send = state.drive_send;
  assign group_halt = state.group_halt;
  assign tune_start = state.tune_start;
endmodule : agcc_checker
`default_nettype wire

/* tb/agcc_checker_props.sv */
`timescale 1ns/1ps
`default_nettype none
module agcc_checker_props #(
  parameter int AXES = 4
) (
  // Clock, reset and bus.
  input wire logic clock, rst_n, psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata, prdata, drive_position,
  // Status and drive side.
  input wire logic module_run, link_up, group_ready, op_done, drive_send, group_halt, tune_start,
  input wire logic [AXES-1:0] axis_servo_on, axis_fault
);
  logic wr_cmd;
  logic mv;
  logic moving;
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_n);
  assign wr_cmd = psel && penable && pready && pwrite && paddr == agcc_pkg::ADDR_CMD;
  assign mv = wr_cmd && pwdata[2:0] == agcc_pkg::OP_MOVE;
  // Abort checks only apply once a move has really been launched to the drives.
  always_ff @(posedge clock) begin
    if (!rst_n || group_halt || op_done) begin
      moving <= 1'b0;
    end else if (drive_send) begin
      moving <= 1'b1;
    end
  end
  property p_tune_run;
    wr_cmd && pwdata[2:0] == agcc_pkg::OP_TUNE && module_run |=> !tune_start;
  endproperty
  a_tune_run: assert property (p_tune_run) else $error("tuning started in run");
  property p_tune_stop;
    wr_cmd && pwdata[2:0] == agcc_pkg::OP_TUNE && !module_run |=> tune_start;
  endproperty
  a_tune_stop: assert property (p_tune_stop) else $error("tuning not started in stop");
  property p_not_ready;
    mv && !group_ready |=> !drive_send;
  endproperty
  a_not_ready: assert property (p_not_ready) else $error("move sent while group not ready");
  property p_servo_off;
    mv && !(&axis_servo_on) |=> !drive_send;
  endproperty
  a_servo_off: assert property (p_servo_off) else $error("move sent with an axis off");
  property p_fault_halt;
    $rose(|axis_fault) |-> ##[1:3] group_halt;
  endproperty
  a_fault_halt: assert property (p_fault_halt) else $error("axis fault did not halt group");
  property p_stop_abort;
    moving && $fell(module_run) |-> ##[1:3] group_halt;
  endproperty
  a_stop_abort: assert property (p_stop_abort) else $error("stop did not abort move");
  property p_link_abort;
    moving && $fell(link_up) |-> ##[1:3] group_halt;
  endproperty
  a_link_abort: assert property (p_link_abort) else $error("link loss did not abort move");
  property p_error_ro;
    psel && penable && pready && pwrite && paddr == agcc_pkg::ADDR_ERROR |-> pslverr;
  endproperty
  a_error_ro: assert property (p_error_ro) else $error("error code write not refused");
endmodule : agcc_checker_props
bind agcc_checker agcc_checker_props #(.AXES(AXES)) i_agcc_checker_props (.clock(clock), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .drive_position(drive_position), .module_run(module_run),
  .link_up(link_up), .group_ready(group_ready), .op_done(op_done), .drive_send(drive_send),
  .group_halt(group_halt), .tune_start(tune_start), .axis_servo_on(axis_servo_on), .axis_fault(axis_fault));
`default_nettype wire

/* tb/agcc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module agcc_host_model (
  // Clock.
  input wire logic clock,
  // Bus request.
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // Bus answer.
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err, output logic hung);
    hung = 1'b1;
    q = 32'h0000_0000;
    err = 1'b0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (int n = 0; n < 16 && hung; n++) begin
      @(posedge clock);
      if (pready === 1'b1) begin
        q = prdata;
        err = pslverr;
        hung = 1'b0;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // A released bus must not keep showing the last request.
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : agcc_host_model
`default_nettype wire

/* tb/test_axis_group_command_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module test_axis_group_command_checker;
  localparam int AXES = 4;
  localparam logic [7:0] GA [8] = '{agcc_pkg::ADDR_POS, agcc_pkg::ADDR_SCALE, agcc_pkg::ADDR_SPEED,
    agcc_pkg::ADDR_ACCEL, agcc_pkg::ADDR_DECEL, agcc_pkg::ADDR_JERK, agcc_pkg::ADDR_MODES, agcc_pkg::ADDR_BLEND};
  // Good set sits on the boundaries: lowest pulse value, top speed, top selectors, top blend.
  localparam logic [31:0] GV [8] = '{32'hc000_0000, 32'h0000_0002, 32'h0000_ffff, 32'h0, 32'h0, 32'h0,
    32'h0001_0105, 32'h0000_0064};
  localparam int BI [12] = '{1, 2, 2, 2, 3, 4, 5, 6, 6, 6, 7, 7};
  localparam logic [31:0] BV [12] = '{32'h3, 32'h0, 32'h0001_0000, 32'hffff_ffff, 32'hffff_ffff,
    32'hffff_ffff, 32'hffff_ffff, 32'h6, 32'h0000_0200, 32'h0002_0000, 32'h0000_0065, 32'hffff_ffff};
  localparam logic [15:0] BC [12] = '{agcc_pkg::ERR_POS_RANGE, agcc_pkg::ERR_SPEED, agcc_pkg::ERR_SPEED,
    agcc_pkg::ERR_SPEED, agcc_pkg::ERR_ACCEL, agcc_pkg::ERR_DECEL, agcc_pkg::ERR_JERK, agcc_pkg::ERR_QUEUE,
    agcc_pkg::ERR_LAUNCH, agcc_pkg::ERR_BLENDSEL, agcc_pkg::ERR_BLENDVAL, agcc_pkg::ERR_BLENDVAL};
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, module_run, link_up, group_ready, op_done;
  logic drive_send, group_halt, tune_start, rerr, hung;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, drive_position, rq, last_pos;
  logic [AXES-1:0] axis_servo_on, axis_fault;
  int fails = 0;
  int check_count = 0;
  int sends = 0;
  int tunes = 0;
  agcc_checker #(.AXES(AXES)) i_agcc_checker (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .module_run(module_run), .link_up(link_up), .group_ready(group_ready), .axis_servo_on(axis_servo_on),
    .axis_fault(axis_fault), .op_done(op_done), .drive_position(drive_position), .drive_send(drive_send),
    .group_halt(group_halt), .tune_start(tune_start));
  agcc_host_model i_agcc_host_model (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    if (drive_send === 1'b1) begin
      sends <= sends + 1;
      last_pos <= drive_position;
    end
    if (tune_start === 1'b1) begin
      tunes <= tunes + 1;
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    i_agcc_host_model.xfer(wr, a, d, rq, rerr, hung);
    if (hung) begin
      fails++;
      tally_and_finish();
    end
  endtask : bus
  task automatic cmd(input logic [2:0] op);
    bus(1'b1, agcc_pkg::ADDR_CMD, {29'h0, op});
  endtask : cmd
  task automatic err_is(input logic [15:0] code);
    bus(1'b0, agcc_pkg::ADDR_ERROR, 32'h0);
    check("error code", rq, {16'h0000, code});
  endtask : err_is
  task automatic wait_halt(input logic lvl);
    int n;
    n = 0;
    while (group_halt !== lvl && n < 50) begin
      @(posedge clock);
      n++;
    end
    if (n == 50) begin
      fails++;
      tally_and_finish();
    end
  endtask : wait_halt
  task automatic pulse_done;
    op_done <= 1'b1;
    @(posedge clock);
    op_done <= 1'b0;
  endtask : pulse_done
  task automatic t_regs;
    bus(1'b0, agcc_pkg::ADDR_SCALE, 32'h0);
    check("scale", rq, agcc_pkg::SCALE_RESET);
    bus(1'b0, agcc_pkg::ADDR_BLENDMAX, 32'h0);
    check("blend max", rq, agcc_pkg::BLENDMAX_RESET);
    bus(1'b0, 8'h38, 32'h0);
    check("unmapped", {31'h0, rerr}, 32'h1);
    bus(1'b1, agcc_pkg::ADDR_ERROR, 32'h0000_2013);
    err_is(agcc_pkg::ERR_NONE);
  endtask : t_regs
  task automatic t_tune;
    int t;
    t = tunes;
    cmd(agcc_pkg::OP_TUNE);
    err_is(agcc_pkg::ERR_TUNE_RUN);
    check("tune pulses", 32'(tunes), 32'(t));
    module_run <= 1'b0;
    cmd(agcc_pkg::OP_RESET);
    cmd(agcc_pkg::OP_TUNE);
    err_is(agcc_pkg::ERR_NONE);
    check("tune pulses", 32'(tunes), 32'(t + 1));
    module_run <= 1'b1;
  endtask : t_tune
  task automatic t_gate;
    group_ready <= 1'b0;
    cmd(agcc_pkg::OP_MOVE);
    err_is(agcc_pkg::ERR_NOT_READY);
    group_ready <= 1'b1;
    axis_servo_on <= 4'b1011;
    cmd(agcc_pkg::OP_MOVE);
    err_is(agcc_pkg::ERR_SERVO_OFF);
    axis_servo_on <= 4'b1111;
  endtask : t_gate
  task automatic t_params;
    int s;
    for (int i = 0; i < 12; i++) begin
      s = sends;
      bus(1'b1, GA[BI[i]], BV[i]);
      cmd(agcc_pkg::OP_MOVE);
      err_is(BC[i]);
      check("sends", 32'(sends), 32'(s));
      bus(1'b1, GA[BI[i]], GV[BI[i]]);
    end
  endtask : t_params
  task automatic t_move;
    int s;
    s = sends;
    cmd(agcc_pkg::OP_RESET);
    cmd(agcc_pkg::OP_MOVE);
    err_is(agcc_pkg::ERR_NONE);
    check("sends", 32'(sends), 32'(s + 1));
    check("pulses", last_pos, 32'h8000_0000);
    cmd(agcc_pkg::OP_MOVE);
    err_is(agcc_pkg::ERR_ST_MOVING);
    pulse_done();
    cmd(agcc_pkg::OP_HALT);
    err_is(agcc_pkg::ERR_ST_STANDBY);
    cmd(agcc_pkg::OP_HOME);
    cmd(agcc_pkg::OP_MOVE);
    err_is(agcc_pkg::ERR_ST_HOMING);
    pulse_done();
    cmd(agcc_pkg::OP_MOVE);
    cmd(agcc_pkg::OP_HALT);
    wait_halt(1'b1);
    wait_halt(1'b0);
    err_is(agcc_pkg::ERR_ST_HOMING);
    bus(1'b0, agcc_pkg::ADDR_STATUS, 32'h0);
    check("status", rq, 32'h0000_00f1);
  endtask : t_move
  task automatic t_abort(input logic by_stop, input logic [15:0] code);
    cmd(agcc_pkg::OP_MOVE);
    repeat (2) @(posedge clock);
    if (by_stop) begin
      module_run <= 1'b0;
    end else begin
      link_up <= 1'b0;
    end
    wait_halt(1'b1);
    err_is(code);
    wait_halt(1'b0);
    module_run <= 1'b1;
    link_up <= 1'b1;
  endtask : t_abort
  task automatic t_fault;
    cmd(agcc_pkg::OP_MOVE);
    axis_fault <= 4'b0100;
    wait_halt(1'b1);
    err_is(agcc_pkg::ERR_AXIS_FAULT);
    cmd(agcc_pkg::OP_MOVE);
    err_is(agcc_pkg::ERR_ST_FAULT);
    cmd(agcc_pkg::OP_RESET);
    check("halt held", {31'h0, group_halt}, 32'h1);
    axis_fault <= 4'b0000;
    cmd(agcc_pkg::OP_RESET);
    wait_halt(1'b0);
    err_is(agcc_pkg::ERR_NONE);
  endtask : t_fault
  initial begin
    rst_n = 1'b0;
    module_run = 1'b1;
    link_up = 1'b1;
    group_ready = 1'b1;
    op_done = 1'b0;
    axis_servo_on = 4'b1111;
    axis_fault = 4'b0000;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_regs();
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, GA[i], GV[i]);
    end
    t_tune();
    t_gate();
    t_params();
    t_move();
    t_abort(1'b1, agcc_pkg::ERR_MODULE_STOP);
    t_abort(1'b0, agcc_pkg::ERR_LINK_LOST);
    t_fault();
    tally_and_finish();
  end
endmodule : test_axis_group_command_checker
`default_nettype wire
